/* File: rtl/logic_block_params.svh */
`ifndef LOGIC_BLOCK_PARAMS_SVH
`define LOGIC_BLOCK_PARAMS_SVH

// Block dimensions
`define NUM_CELLS       16
`define NUM_PINS        8
`define NUM_CLUSTERS    16
`define TERMS_PER_CELL  5
`define POOL_TERMS      80
`define MAX_TERMS_SYNC  20
`define MAX_TERMS_ASYNC 18
`define NUM_GCLK        4
`define NUM_BCLK        4
`define CLUSTER_SPAN    4
`define PIN_CHOICES     4
`define CELL_CHOICES    8

`endif

/* File: rtl/logic_block_pkg.sv */
package logic_block_pkg;

  `include "logic_block_params.svh"

  typedef enum logic [2:0] {
    MODE_COMB  = 3'h1,
    MODE_REG   = 3'h2,
    MODE_LATCH = 3'h4
  } cell_mode_t;

  // Static per-cell configuration
  typedef struct packed {
    cell_mode_t  mode;
    logic        asyncMode;
    logic        xorEnable;
    logic        xorInvert;
    logic [1:0]  blockClkSel;
    logic        usePtClk;
    logic        ptClkFalling;
    logic        ptInitPreset;
    logic [3:0]  clusterUse;
    logic        keepOneTerm;
  } cell_cfg_t;

  // Static per-pin configuration
  typedef struct packed {
    logic [2:0]  cellSel;
    logic        inLatch;
    logic [1:0]  inClkSel;
  } pin_cfg_t;

  // Values handed to the input routing
  typedef struct packed {
    logic [`NUM_PINS-1:0]  direct;
    logic [`NUM_PINS-1:0]  captured;
  } pin_in_t;

endpackage : logic_block_pkg

/* File: rtl/term_allocator.sv */
`timescale 1ns/100ps
`include "logic_block_params.svh"
// Steers product-term clusters to cells and counts terms per cell.
module term_allocator
  import logic_block_pkg::*;
#(
  parameter int NC = `NUM_CLUSTERS
) (
  // Terms, five per cluster
  input  wire logic [`POOL_TERMS-1:0]        terms,
  input  wire cell_cfg_t [`NUM_CELLS-1:0]    cfg,
  // Sum of products per cell
  output logic [`NUM_CELLS-1:0]              sumTerm,
  output logic [`NUM_CELLS-1:0]              firstTerm,
  output logic [`NUM_CELLS-1:0]              overLimit
);

  // ------------------------------------------------------------
  // Cluster index helper
  // ------------------------------------------------------------
  // Slot k of cell m maps to cluster m-1+k, cell 0 starts at cluster 0; invalid slots return NC
  function automatic int slotCluster(input int m, input int k);
    int c;
    c = (m == 0) ? k : m - 1 + k;
    if (c < 0 || c >= NC || (m == 0 && k == 3)) return NC;
    return c;
  endfunction : slotCluster

  function automatic logic clusterOr(input logic [`POOL_TERMS-1:0] t, input int c,
                                     input logic skipLast);
    logic r;
    r = 1'b0;
    for (int j = 0; j < `TERMS_PER_CELL; j++) begin
      if (!(skipLast && j == 0)) r = r | t[c*`TERMS_PER_CELL+j];
    end
    return r;
  endfunction : clusterOr

  // ------------------------------------------------------------
  // Allocation
  // ------------------------------------------------------------
  always_comb begin
    int cnt;
    int c;
    int lim;
    cnt = 0;
    c   = 0;
    lim = 0;
    for (int m = 0; m < `NUM_CELLS; m++) begin
      sumTerm[m]   = 1'b0;
      cnt          = 0;
      // One term kept home when four of five leave
      firstTerm[m] = cfg[m].keepOneTerm & terms[m*`TERMS_PER_CELL];
      for (int k = 0; k < `CLUSTER_SPAN; k++) begin
        c = slotCluster(m, k);
        if (c < NC && cfg[m].clusterUse[k]) begin
          sumTerm[m] = sumTerm[m] | clusterOr(terms, c, (c == m) && cfg[m].keepOneTerm);
          cnt        = cnt + `TERMS_PER_CELL;
        end
      end
      lim          = cfg[m].asyncMode ? `MAX_TERMS_ASYNC : `MAX_TERMS_SYNC;
      overLimit[m] = (cnt > lim);
    end
  end

endmodule : term_allocator

/* File: rtl/logic_block.sv */
`timescale 1ns/100ps
`include "logic_block_params.svh"
// ------------------------------------------------------------
// ------------------------------------------------------------
// The array is emulated on clk: block clocks and term clocks are sampled levels whose
// edges become one-cycle enables, latch gates act on the level. Asynchronous init acts
// only on the next clk edge, as a registered set/clear with priority over data.
module logic_block
  import logic_block_pkg::*;
(
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  // Global clock pins
  input  wire logic [`NUM_GCLK-1:0]            globalClk,
  // Product terms from the array
  input  wire logic [`POOL_TERMS-1:0]          logicTerms,
  input  wire logic [`NUM_CELLS-1:0]           ptClock,
  input  wire logic [`NUM_CELLS-1:0]           ptInit,
  input  wire logic [`NUM_PINS-1:0]            oeTerm,
  input  wire logic                            blockInitA,
  input  wire logic                            blockInitB,
  // Static configuration
  input  wire cell_cfg_t [`NUM_CELLS-1:0]      cellCfg,
  input  wire pin_cfg_t [`NUM_PINS-1:0]        pinCfg,
  input  wire logic [`NUM_BCLK-1:0][2:0]       bclkSel,
  input  wire logic                            initSwap,
  // Pins
  input  wire logic [`NUM_PINS-1:0]            pinIn,
  output logic [`NUM_PINS-1:0]                 pinOut,
  output logic [`NUM_PINS-1:0]                 pinOe,
  // To routing
  output logic [`NUM_CELLS-1:0]                feedback,
  output pin_in_t                              pinToRouting,
  output logic [`NUM_CELLS-1:0]                termOverflow
);

  // ------------------------------------------------------------
  // Synchronisers for pins and global clocks
  // ------------------------------------------------------------
  logic [`NUM_PINS-1:0] pinMeta_ff;
  logic [`NUM_PINS-1:0] pinSync_ff;
  logic [`NUM_GCLK-1:0] gclkMeta_ff;
  logic [`NUM_GCLK-1:0] gclkSync_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_ff  <= '0;
      pinSync_ff  <= '0;
      gclkMeta_ff <= '0;
      gclkSync_ff <= '0;
    end else begin
      pinMeta_ff  <= pinIn;
      pinSync_ff  <= pinMeta_ff;
      gclkMeta_ff <= globalClk;
      gclkSync_ff <= gclkMeta_ff;
    end
  end

  // ------------------------------------------------------------
  // Block clock generator
  // ------------------------------------------------------------
  // Candidate 2g is true clock g, 2g+1 its complement
  logic [`NUM_BCLK-1:0] bclk;
  logic [`NUM_BCLK-1:0] bclkPrev_ff;
  logic [`NUM_BCLK-1:0] bclkRise;

  always_comb begin
    for (int b = 0; b < `NUM_BCLK; b++) begin
      bclk[b] = gclkSync_ff[bclkSel[b][2:1]] ^ bclkSel[b][0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) bclkPrev_ff <= '0;
    else        bclkPrev_ff <= bclk;
  end

  // Detectors start blind after reset, so a level already high is not an edge
  logic edgeArm_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) edgeArm_ff <= 1'b0;
    else        edgeArm_ff <= 1'b1;
  end

  assign bclkRise = bclk & ~bclkPrev_ff & {`NUM_BCLK{edgeArm_ff}};

  // ------------------------------------------------------------
  // Term allocation and XOR
  // ------------------------------------------------------------
  logic [`NUM_CELLS-1:0] sumTerm;
  logic [`NUM_CELLS-1:0] firstTerm;
  logic [`NUM_CELLS-1:0] overLimit;
  logic [`NUM_CELLS-1:0] cellD;

  // Default (all-zero) configuration gives cell m no cluster, no terms
  term_allocator #(.NC(`NUM_CLUSTERS)) u_alloc (
    .terms     (logicTerms),
    .cfg       (cellCfg),
    .sumTerm   (sumTerm),
    .firstTerm (firstTerm),
    .overLimit (overLimit)
  );

  logic [`NUM_CELLS-1:0] cellQ_ff;

  // XOR with the kept term or with own state gives T, J-K, S-R emulation
  always_comb begin
    for (int m = 0; m < `NUM_CELLS; m++) begin
      cellD[m] = sumTerm[m];
      if (cellCfg[m].xorEnable) begin
        cellD[m] = sumTerm[m] ^ (cellCfg[m].keepOneTerm ? firstTerm[m] : cellQ_ff[m]);
      end
      cellD[m] = cellD[m] ^ cellCfg[m].xorInvert;
    end
  end

  // ------------------------------------------------------------
  // Macrocell clocks and init
  // ------------------------------------------------------------
  logic [`NUM_CELLS-1:0] ptClkPrev_ff;
  logic [`NUM_CELLS-1:0] cellEdge;
  logic [`NUM_CELLS-1:0] cellGate;
  logic [`NUM_CELLS-1:0] cellSet;
  logic [`NUM_CELLS-1:0] cellClr;
  logic                  grpPreset;
  logic                  grpReset;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ptClkPrev_ff <= '0;
    else        ptClkPrev_ff <= ptClock;
  end

  assign grpPreset = initSwap ? blockInitB : blockInitA;
  assign grpReset  = initSwap ? blockInitA : blockInitB;

  always_comb begin
    for (int m = 0; m < `NUM_CELLS; m++) begin
      cellEdge[m] = bclkRise[cellCfg[m].blockClkSel];
      cellGate[m] = bclk[cellCfg[m].blockClkSel];
      if (cellCfg[m].asyncMode && cellCfg[m].usePtClk) begin
        cellEdge[m] = cellCfg[m].ptClkFalling ? (ptClkPrev_ff[m] & ~ptClock[m])
                                              : (~ptClkPrev_ff[m] & ptClock[m]);
        cellEdge[m] = cellEdge[m] & edgeArm_ff;
        cellGate[m] = ptClock[m] ^ cellCfg[m].ptClkFalling;
      end
      if (cellCfg[m].asyncMode) begin
        cellSet[m] = ptInit[m] & cellCfg[m].ptInitPreset;
        cellClr[m] = ptInit[m] & ~cellCfg[m].ptInitPreset;
      end else begin
        cellSet[m] = grpPreset;
        cellClr[m] = grpReset;
      end
    end
  end

  // ------------------------------------------------------------
  // Macrocell storage
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cellQ_ff <= '0;
    end else begin
      for (int m = 0; m < `NUM_CELLS; m++) begin
        if (cellClr[m])                                        cellQ_ff[m] <= 1'b0;
        else if (cellSet[m])                                   cellQ_ff[m] <= 1'b1;
        else if (cellCfg[m].mode == MODE_REG && cellEdge[m])   cellQ_ff[m] <= cellD[m];
        else if (cellCfg[m].mode == MODE_LATCH && cellGate[m]) cellQ_ff[m] <= cellD[m];
        else if (cellCfg[m].mode == MODE_COMB)                 cellQ_ff[m] <= cellD[m];
      end
    end
  end

  // Feedback leaves whatever the mode or pin use
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) feedback <= '0;
    else        feedback <= cellQ_ff;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) termOverflow <= '0;
    else        termOverflow <= overLimit;
  end

  // ------------------------------------------------------------
  // Output routing and three-state control
  // ------------------------------------------------------------
  // Choice c of pin i is cell 2i+c, so a pin sees eight cells and a cell four pins
  function automatic int pinCell(input int i, input logic [2:0] sel);
    return (2 * i + int'(sel)) % `NUM_CELLS;
  endfunction : pinCell

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOut <= '0;
      pinOe  <= '0;
    end else begin
      for (int i = 0; i < `NUM_PINS; i++) begin
        pinOut[i] <= cellQ_ff[pinCell(i, pinCfg[i].cellSel)];
        pinOe[i]  <= oeTerm[i];
      end
    end
  end

  // ------------------------------------------------------------
  // Input cell
  // ------------------------------------------------------------
  logic [`NUM_PINS-1:0] capt_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      capt_ff <= '0;
    end else begin
      for (int i = 0; i < `NUM_PINS; i++) begin
        if (pinCfg[i].inLatch ? bclk[pinCfg[i].inClkSel] : bclkRise[pinCfg[i].inClkSel]) begin
          capt_ff[i] <= pinSync_ff[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) pinToRouting <= '0;
    else        pinToRouting <= '{direct: pinSync_ff, captured: capt_ff};
  end

  // Configuration is expected static while running

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_pin_route;
    @(posedge clk) disable iff (!rst_b)
      1'b1 |=> pinOut[0] == $past(cellQ_ff[pinCell(0, pinCfg[0].cellSel)]);
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pin 0 route wrong");

  property p_oe;
    @(posedge clk) disable iff (!rst_b) 1'b1 |=> pinOe == $past(oeTerm);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");

  property p_grp_reset;
    @(posedge clk) disable iff (!rst_b)
      (grpReset && !cellCfg[3].asyncMode) |=> !cellQ_ff[3];
  endproperty
  a_grp_reset: assert property (p_grp_reset) else $error("group reset missed");

  property p_grp_preset;
    @(posedge clk) disable iff (!rst_b)
      (grpPreset && !grpReset && !cellCfg[3].asyncMode) |=> cellQ_ff[3];
  endproperty
  a_grp_preset: assert property (p_grp_preset) else $error("group preset missed");

  property p_async_init;
    @(posedge clk) disable iff (!rst_b)
      (cellCfg[5].asyncMode && ptInit[5] && cellCfg[5].ptInitPreset) |=> cellQ_ff[5];
  endproperty
  a_async_init: assert property (p_async_init) else $error("cell init missed");

  property p_feedback;
    @(posedge clk) disable iff (!rst_b) 1'b1 |=> feedback == $past(cellQ_ff);
  endproperty
  a_feedback: assert property (p_feedback) else $error("feedback lost");

  property p_hold_reg;
    @(posedge clk) disable iff (!rst_b)
      (cellCfg[2].mode == MODE_REG && !cellEdge[2] && !cellSet[2] && !cellClr[2])
        |=> $stable(cellQ_ff[2]);
  endproperty
  a_hold_reg: assert property (p_hold_reg) else $error("register moved off edge");

  property p_direct;
    @(posedge clk) disable iff (!rst_b)
      1'b1 |-> ##3 pinToRouting.direct == $past(pinIn, 3);
  endproperty
  a_direct: assert property (p_direct) else $error("direct pin path wrong");

  property p_limit;
    @(posedge clk) disable iff (!rst_b)
      (cellCfg[6].asyncMode && cellCfg[6].clusterUse == 4'hF) |=> termOverflow[6];
  endproperty
  a_limit: assert property (p_limit) else $error("async term limit not flagged");

  property p_latch_follow;
    @(posedge clk) disable iff (!rst_b)
      (cellCfg[4].mode == MODE_LATCH && cellGate[4] && !cellSet[4] && !cellClr[4])
        |=> cellQ_ff[4] == $past(cellD[4]);
  endproperty
  a_latch_follow: assert property (p_latch_follow) else $error("open latch stale");

  property p_comb_follow;
    @(posedge clk) disable iff (!rst_b)
      (cellCfg[1].mode == MODE_COMB && !cellSet[1] && !cellClr[1])
        |=> cellQ_ff[1] == $past(cellD[1]);
  endproperty
  a_comb_follow: assert property (p_comb_follow) else $error("comb cell stale");

  property p_reg_load;
    @(posedge clk) disable iff (!rst_b)
      (cellCfg[2].mode == MODE_REG && !cellCfg[2].asyncMode && !cellSet[2] && !cellClr[2]
       && bclkRise[cellCfg[2].blockClkSel]) |=> cellQ_ff[2] == $past(cellD[2]);
  endproperty
  a_reg_load: assert property (p_reg_load) else $error("block clock edge missed");

  property p_pt_edge;
    @(posedge clk) disable iff (!rst_b)
      (edgeArm_ff && cellCfg[7].mode == MODE_REG && cellCfg[7].asyncMode
       && cellCfg[7].usePtClk && !cellCfg[7].ptClkFalling && !ptClkPrev_ff[7] && ptClock[7]
       && !cellSet[7] && !cellClr[7]) |=> cellQ_ff[7] == $past(cellD[7]);
  endproperty
  a_pt_edge: assert property (p_pt_edge) else $error("term clock rise missed");

  property p_capture_reg;
    @(posedge clk) disable iff (!rst_b)
      (!pinCfg[0].inLatch && bclkRise[pinCfg[0].inClkSel])
        |=> capt_ff[0] == $past(pinSync_ff[0]);
  endproperty
  a_capture_reg: assert property (p_capture_reg) else $error("input register missed");

  property p_sync_limit;
    @(posedge clk) disable iff (!rst_b) !cellCfg[9].asyncMode |=> !termOverflow[9];
  endproperty
  a_sync_limit: assert property (p_sync_limit) else $error("sync cell flagged");

  property p_bclk_pick;
    @(posedge clk) disable iff (!rst_b) (bclkSel[0] == 3'h3) |-> bclk[0] == !gclkSync_ff[1];
  endproperty
  a_bclk_pick: assert property (p_bclk_pick) else $error("block clock pick wrong");

  c_reg_edge:  cover property (@(posedge clk) disable iff (!rst_b) cellEdge[0] && cellD[0]);
  c_pin_drive: cover property (@(posedge clk) disable iff (!rst_b) pinOe[1] && pinOut[1]);
  c_capture:   cover property (@(posedge clk) disable iff (!rst_b) $rose(capt_ff[2]));
  c_latch_on:  cover property (@(posedge clk) disable iff (!rst_b)
                 cellGate[4] && cellCfg[4].mode == MODE_LATCH);
  c_pt_fall:   cover property (@(posedge clk) disable iff (!rst_b)
                 cellEdge[7] && cellCfg[7].ptClkFalling);

endmodule : logic_block

/* File: verif/pin_board_model.sv */
`timescale 1ns/100ps
// Board logic on the pin side of the block
module pin_board_model (
  // Device side
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  // Board side
  input  wire logic       boardEn,
  input  wire logic [7:0] boardVal,
  // Resolved levels
  output logic [7:0]      pinLevel
);
  // Board drives only pins the device has released; pull-ups hold the rest
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pinOe[i]) pinLevel[i] = pinOut[i];
      else if (boardEn) pinLevel[i] = boardVal[i];
      else pinLevel[i] = 1'b1;
    end
  end
endmodule : pin_board_model

/* File: verif/logic_block_tb.sv */
`timescale 1ns/100ps
`include "logic_block_params.svh"
module logic_block_tb;
  import logic_block_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                  clk, rst_b, blockInitA, blockInitB, initSwap, boardEn;
  logic [3:0]            globalClk;
  logic [79:0]           logicTerms;
  logic [15:0]           ptClock, ptInit, feedback, termOverflow, expFb, expOv;
  logic [7:0]            oeTerm, pinIn, pinOut, pinOe, boardVal, expPin, expLvl;
  cell_cfg_t [15:0]      cellCfg;
  pin_cfg_t [7:0]        pinCfg;
  logic [3:0][2:0]       bclkSel;
  pin_in_t               pinToRouting;
  logic [95:0]           rnd;
  logic [2:0]            cv;
  logic [1:0]            bsel;
  int                    mismatches, comparisons, cycles, seed, rv;

  logic_block dut (.clk, .rst_b, .globalClk, .logicTerms, .ptClock, .ptInit, .oeTerm,
    .blockInitA, .blockInitB, .cellCfg, .pinCfg, .bclkSel, .initSwap, .pinIn, .pinOut,
    .pinOe, .feedback, .pinToRouting, .termOverflow);
  pin_board_model board (.pinOut, .pinOe, .boardEn, .boardVal, .pinLevel(pinIn));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Runs take some 510 cycles; the ceiling only catches a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk16
  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk8
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // Slot k of cell m names cluster m-1+k; cell 0 starts at cluster 0
  function automatic int clus(input int m, input int k);
    return (m == 0) ? ((k == 3) ? 16 : k) : m - 1 + k;
  endfunction : clus
  function automatic logic sumOf(input int m, input logic [3:0] u, input logic keep);
    logic s;
    int   c;
    s = 1'b0;
    for (int k = 0; k < 4; k++) begin
      c = clus(m, k);
      if (u[k] && c < 16) begin
        s = s | ((keep && c == m) ? |logicTerms[5*c+1 +: 4] : |logicTerms[5*c +: 5]);
      end
    end
    return s;
  endfunction : sumOf
  function automatic logic ovf(input int m, input logic [3:0] u, input logic as);
    int n;
    n = 0;
    for (int k = 0; k < 4; k++) if (u[k] && clus(m, k) < 16) n++;
    return (n * 5) > (as ? 18 : 20);
  endfunction : ovf
  task automatic expAll;
    for (int m = 0; m < 16; m++) begin
      expFb[m] = sumOf(m, cellCfg[m].clusterUse, cellCfg[m].keepOneTerm)
               ^ (cellCfg[m].xorEnable & logicTerms[5*m]) ^ cellCfg[m].xorInvert;
      expOv[m] = ovf(m, cellCfg[m].clusterUse, cellCfg[m].asyncMode);
    end
    for (int i = 0; i < 8; i++) begin
      expPin[i] = expFb[(2*i + int'(pinCfg[i].cellSel)) % 16];
    end
  endtask : expAll
  task automatic setLvl;
    expLvl = (oeTerm & expPin) | (~oeTerm & (boardEn ? boardVal : 8'hFF));
  endtask : setLvl
  task automatic newTerms;
    rnd = {$random(seed), $random(seed), $random(seed)};
    logicTerms = rnd[79:0];
    rv = $random(seed);
    oeTerm = rv[7:0];
    boardVal = rv[15:8];
    boardEn = rv[16];
  endtask : newTerms
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    seed = 32'hDD97;
    rst_b = 1'b0;
    {globalClk, logicTerms, ptClock, ptInit, oeTerm, boardVal} = '0;
    {blockInitA, blockInitB, initSwap, boardEn} = '0;
    cellCfg = '0;
    pinCfg = '0;
    bclkSel = '0;
    wt(5);
    rst_b = 1'b1;
    @(negedge clk);
    chk16("feedback", 16'h0000, feedback);
    // Combinational cells: own cluster with kept term and XOR, then random clusters
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 8; r++) begin
        newTerms();
        for (int m = 0; m < 16; m++) begin
          rv = $random(seed);
          cellCfg[m] = '0;
          cellCfg[m].mode = MODE_COMB;
          cellCfg[m].asyncMode = rv[0];
          cellCfg[m].keepOneTerm = (p == 0) & rv[1];
          cellCfg[m].xorEnable = (p == 0) & rv[1] & rv[2];
          cellCfg[m].clusterUse = (p == 0) ? ((m == 0) ? 4'h1 : 4'h2) : rv[7:4];
        end
        for (int i = 0; i < 8; i++) begin
          rv = $random(seed);
          pinCfg[i] = '0;
          pinCfg[i].cellSel = rv[2:0];
        end
        wt(6);
        expAll();
        setLvl();
        chk16("feedback", expFb, feedback);
        chk16("termOverflow", expOv, termOverflow);
        chk8("pinOut", expPin, pinOut);
        chk8("pinOe", oeTerm, pinOe);
        chk8("direct", expLvl, pinToRouting.direct);
      end
    end
    // Registered cells and input registers on each of the eight clock candidates
    for (int c = 0; c < 8; c++) begin
      cv = 3'(c);
      rv = $random(seed);
      bsel = rv[1:0];
      for (int k = 0; k < 4; k++) bclkSel[k] = (k == int'(bsel)) ? cv : cv ^ 3'h1;
      globalClk = {4{cv[0]}};
      for (int m = 0; m < 16; m++) begin
        rv = $random(seed);
        cellCfg[m] = '0;
        cellCfg[m].mode = MODE_REG;
        cellCfg[m].blockClkSel = bsel;
        cellCfg[m].clusterUse = rv[3:0];
      end
      for (int i = 0; i < 8; i++) begin
        rv = $random(seed);
        pinCfg[i] = '0;
        pinCfg[i].cellSel = rv[2:0];
        pinCfg[i].inClkSel = bsel;
      end
      wt(6);
      newTerms();
      oeTerm = 8'h00;
      wt(6);
      setLvl();
      globalClk[cv[2:1]] = ~cv[0];
      wt(6);
      expAll();
      chk16("feedback", expFb, feedback);
      chk8("captured", expLvl, pinToRouting.captured);
      for (int i = 0; i < 8; i++) pinCfg[i].inLatch = 1'b1;
      newTerms();
      oeTerm = 8'h00;
      wt(6);
      setLvl();
      chk16("feedback", expFb, feedback);
      chk8("captured", expLvl, pinToRouting.captured);
    end
    // Block init on sync cells with both swap settings, own init on async cells
    for (int j = 0; j < 4; j++) begin
      cv = 3'(j);
      initSwap = cv[1];
      for (int m = 1; m < 16; m += 2) begin
        rv = $random(seed);
        cellCfg[m].asyncMode = 1'b1;
        cellCfg[m].ptInitPreset = rv[0];
      end
      wt(6);
      blockInitA = ~cv[0];
      blockInitB = cv[0];
      wt(6);
      for (int m = 0; m < 16; m += 2) expFb[m] = ~cv[0] ^ cv[1];
      chk16("feedback", expFb, feedback);
      blockInitA = 1'b0;
      blockInitB = 1'b0;
      ptInit = 16'hAAAA;
      wt(6);
      for (int m = 1; m < 16; m += 2) expFb[m] = cellCfg[m].ptInitPreset;
      chk16("feedback", expFb, feedback);
      ptInit = 16'h0000;
    end
    // Async cells on either edge of their own term clock
    for (int r = 0; r < 4; r++) begin
      for (int m = 0; m < 16; m++) begin
        rv = $random(seed);
        cellCfg[m] = '0;
        cellCfg[m].mode = MODE_REG;
        cellCfg[m].asyncMode = 1'b1;
        cellCfg[m].usePtClk = 1'b1;
        cellCfg[m].ptClkFalling = rv[0];
        cellCfg[m].clusterUse = {1'b0, rv[6:4]};
        ptClock[m] = rv[0];
      end
      wt(6);
      newTerms();
      wt(6);
      ptClock = ~ptClock;
      wt(6);
      expAll();
      chk16("feedback", expFb, feedback);
      ptClock = ~ptClock;
      newTerms();
      wt(6);
      chk16("feedback", expFb, feedback);
    end
    // Latched async cells follow data while their gate is open, with output inversion
    for (int r = 0; r < 4; r++) begin
      for (int m = 0; m < 16; m++) begin
        rv = $random(seed);
        cellCfg[m] = '0;
        cellCfg[m].mode = MODE_LATCH;
        cellCfg[m].asyncMode = 1'b1;
        cellCfg[m].usePtClk = 1'b1;
        cellCfg[m].ptClkFalling = rv[0];
        cellCfg[m].xorInvert = rv[1];
        cellCfg[m].clusterUse = rv[7:4];
        ptClock[m] = ~rv[0];
      end
      newTerms();
      wt(6);
      expAll();
      chk16("feedback", expFb, feedback);
      chk16("termOverflow", expOv, termOverflow);
      ptClock = ~ptClock;
      newTerms();
      wt(6);
      chk16("feedback", expFb, feedback);
    end
    conclude();
  end
endmodule : logic_block_tb
